// *** design/weg_guard.sv ***
// Watchdog timer with end-of-init protection line behind an AXI4-Lite slave
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
// What this block does
// R1 - The watchdog count is a 16-bit up counter.
// R2 - The counter advances at the system clock divided by 256 or 16384, chosen by a config bit.
// R3 - Normal mode reloads a software value, time-out and prewarning modes a fixed value.
// R4 - An enabled watchdog resets the system unless software services it in time.
// R5 - The end-of-init bit drives a protection line; guarded writes need supervisor and bit 0.
// R6 - Every change of the end-of-init bit is watched and reported.
// R7 - An error first raises an NMI and only a further period later the system reset.
// R8 - Software changes the watchdog by two writes whose spacing is monitored and limited.
// R9 - The first write is checked against a password of fixed and user fields.
// R10 - A wrong password or wrong guard bits start the reset sequence.
// R11 - A counter overflow starts the reset sequence.
// R12 - The time-out can be disabled while password and end-of-init checks stay active.
// R13 - A second watchdog reset holds the chip in reset until power-on or hardware reset.
// R14 - The watchdog delivers an event that returns the system from idle or sleep to run.
// R15 - In idle or sleep a count step from 7FFF to 8000 hex signals wake-up.
// R16 - A correct two-write service reloads the counter and ends any time-out condition.
module weg_guard #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    input wire logic low_power,
    output logic endinit_line,
    output logic wd_nmi,
    output logic wd_reset,
    output logic wd_wake,
    output logic irq
);
    // Bus slave state
    logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
    logic [1:0] bresp_q, rresp_q;
    logic [31:0] rdata_q;
    logic aw_got_q, w_got_q;
    logic [7:0] awaddr_q;
    logic awpriv_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    // Watchdog state
    weg_pkg::weg_mode_t mode_q, mode_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] reload_q, reload_d;
    logic [5:0] pwu_q, pwu_d;
    logic locked_q, locked_d;
    logic endinit_q, endinit_d;
    logic seen_q, seen_d;
    logic [4:0] rst_cnt_q, rst_cnt_d;
    logic dis_q, slow_q;
    logic nmi_q, reset_q, wake_q, irq_q;
    logic [weg_pkg::IRQ_W-1:0] stat_q, en_q;

    // Handshakes and the single write execution point
    wire aw_hs = awvalid && awready_q;
    wire w_hs = wvalid && wready_q;
    wire ar_hs = arvalid && arready_q;
    wire wr_fire = aw_got_q && w_got_q && !bvalid_q;
    wire [31:0] bmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    // Write address decode
    wire ws_ctrl = awaddr_q == weg_pkg::OFF_CTRL;
    wire ws_cfg = awaddr_q == weg_pkg::OFF_CFG;
    wire ws_stat = awaddr_q == weg_pkg::OFF_STAT;
    wire ws_ist = awaddr_q == weg_pkg::OFF_IRQ_STAT;
    wire ws_ien = awaddr_q == weg_pkg::OFF_IRQ_EN;
    wire ws_icl = awaddr_q == weg_pkg::OFF_IRQ_CLR;
    wire wr_mapped = ws_ctrl || ws_cfg || ws_stat || ws_ist || ws_ien || ws_icl;

    // Control word as read, and merged with the byte lanes written
    wire [31:0] ctrl_rd = {reload_q, weg_pkg::PW_FIXED, pwu_q, locked_q, endinit_q};
    wire [31:0] ctrl_wr = (wdata_q & bmask) | (ctrl_rd & ~bmask);
    wire [31:0] cfg_rd = {30'h0, slow_q, dis_q};
    wire [31:0] cfg_wr = (wdata_q & bmask) | (cfg_rd & ~bmask);
    wire pw_ok, guard_ok;

    weg_access_check u_check (
        .data(ctrl_wr),
        .pw_user(pwu_q),
        .pw_ok(pw_ok),
        .guard_ok(guard_ok)
    );

    // Two-write sequence classification
    wire ctrl_hit = wr_fire && ws_ctrl;
    wire pw_access = ctrl_hit && locked_q; // [R8]
    wire mod_access = ctrl_hit && !locked_q; // [R8]
    wire acc_err = (pw_access && !pw_ok) || (mod_access && !guard_ok); // [R9] [R10]
    // Guarded write needs privileged access and end-of-init low
    wire cfg_wr_ok = wr_fire && ws_cfg && awpriv_q && !endinit_q; // [R5]

    // Counting and error detection
    wire tick;
    wire live = (mode_q == weg_pkg::ST_NORMAL) || (mode_q == weg_pkg::ST_TIMEOUT);
    wire halted = (mode_q == weg_pkg::ST_RESET) || (mode_q == weg_pkg::ST_HELD);
    // Disable only stops normal mode; time-out keeps the two writes limited
    wire cnt_en = tick && !halted && !(mode_q == weg_pkg::ST_NORMAL && dis_q); // [R12]
    wire ovf = cnt_en && cnt_q == weg_pkg::CNT_TOP; // [R11]
    wire err_trig = live && (acc_err || ovf); // [R4] [R10] [R11]
    wire rst_done = (mode_q == weg_pkg::ST_RESET) && rst_cnt_q == weg_pkg::RST_PULSE_CYC - 5'd1;
    wire wake_evt = cnt_en && cnt_q == weg_pkg::WAKE_FROM && low_power; // [R15]
    wire einit_evt = endinit_d != endinit_q; // [R6]
    wire [weg_pkg::IRQ_W-1:0] evt = {einit_evt, wake_evt, err_trig, live && ovf, live && acc_err};
    wire [weg_pkg::IRQ_W-1:0] clr = (wr_fire && ws_icl) ? wdata_q[weg_pkg::IRQ_W-1:0]
        & bmask[weg_pkg::IRQ_W-1:0] : '0;

    weg_prescaler #(
        .DIV_FAST(weg_pkg::DIV_FAST),
        .DIV_SLOW(weg_pkg::DIV_SLOW)
    ) u_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .slow(slow_q),
        .tick(tick)
    );

    // Mode sequencing; an error outranks a service in the same cycle
    always_comb begin
        mode_d = mode_q;
        cnt_d = cnt_en ? cnt_q + 16'd1 : cnt_q; // [R1] [R2]
        reload_d = reload_q;
        pwu_d = pwu_q;
        locked_d = locked_q;
        endinit_d = endinit_q;
        seen_d = seen_q;
        rst_cnt_d = rst_cnt_q;
        case (mode_q)
            weg_pkg::ST_NORMAL, weg_pkg::ST_TIMEOUT: begin
                if (err_trig) begin
                    mode_d = weg_pkg::ST_PREWARN; // [R7]
                    cnt_d = weg_pkg::PREWARN_RELOAD; // [R3]
                    locked_d = 1'b1;
                end else if (pw_access) begin
                    // Open window runs from the fixed reload, overflow ends it
                    mode_d = weg_pkg::ST_TIMEOUT; // [R8]
                    cnt_d = weg_pkg::TIMEOUT_RELOAD; // [R3]
                    locked_d = 1'b0;
                end else if (mod_access) begin
                    mode_d = weg_pkg::ST_NORMAL; // [R16]
                    locked_d = 1'b1;
                    endinit_d = ctrl_wr[weg_pkg::CTL_ENDINIT];
                    pwu_d = ctrl_wr[weg_pkg::CTL_PWU_LSB +: 6];
                    reload_d = ctrl_wr[weg_pkg::CTL_REL_LSB +: 16];
                    cnt_d = ctrl_wr[weg_pkg::CTL_REL_LSB +: 16]; // [R3] [R16]
                end
            end
            weg_pkg::ST_PREWARN: begin
                // Accesses are ignored; only the final overflow matters
                if (ovf) begin
                    rst_cnt_d = 5'd0;
                    mode_d = seen_q ? weg_pkg::ST_HELD : weg_pkg::ST_RESET; // [R7] [R13]
                end
            end
            weg_pkg::ST_RESET: begin
                rst_cnt_d = rst_cnt_q + 5'd1;
                if (rst_done) begin
                    // Restart locked in normal mode with end-of-init set, counter from reload_q; remember this reset
                    mode_d = weg_pkg::ST_NORMAL;
                    seen_d = 1'b1; // [R13]
                    locked_d = 1'b1;
                    endinit_d = 1'b1;
                    cnt_d = reload_q;
                end
            end
            weg_pkg::ST_HELD: begin
                mode_d = weg_pkg::ST_HELD; // [R13]
            end
            default: begin
                mode_d = weg_pkg::ST_NORMAL;
            end
        endcase
    end

    // Watchdog registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q <= weg_pkg::ST_NORMAL;
            cnt_q <= weg_pkg::RELOAD_RST;
            reload_q <= weg_pkg::RELOAD_RST;
            pwu_q <= weg_pkg::PWU_RST;
            locked_q <= 1'b1;
            endinit_q <= 1'b1;
            seen_q <= 1'b0;
            rst_cnt_q <= 5'd0;
        end else begin
            mode_q <= mode_d;
            cnt_q <= cnt_d;
            reload_q <= reload_d;
            pwu_q <= pwu_d;
            locked_q <= locked_d;
            endinit_q <= endinit_d;
            seen_q <= seen_d;
            rst_cnt_q <= rst_cnt_d;
        end
    end

    // Guarded configuration; a watchdog restart returns it to defaults
    always_ff @(posedge aclk) begin
        if (!aresetn || rst_done) begin
            dis_q <= 1'b0;
            slow_q <= 1'b0;
        end else if (cfg_wr_ok) begin
            dis_q <= cfg_wr[weg_pkg::CFG_DIS]; // [R12]
            slow_q <= cfg_wr[weg_pkg::CFG_SLOW]; // [R2]
        end
    end

    // Sticky events, set wins over clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stat_q <= '0;
            en_q <= '0;
        end else begin
            stat_q <= (stat_q & ~clr) | evt;
            if (wr_fire && ws_ien) begin
                en_q <= (wdata_q[weg_pkg::IRQ_W-1:0] & bmask[weg_pkg::IRQ_W-1:0])
                    | (en_q & ~bmask[weg_pkg::IRQ_W-1:0]);
            end
        end
    end

    // System side outputs, all registered
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            nmi_q <= 1'b0;
            reset_q <= 1'b0;
            wake_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            nmi_q <= err_trig; // [R7]
            reset_q <= (mode_d == weg_pkg::ST_RESET) || (mode_d == weg_pkg::ST_HELD); // [R4] [R13]
            wake_q <= wake_evt || err_trig; // [R14] [R15]
            irq_q <= |(stat_q & en_q);
        end
    end

    // Write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            awaddr_q <= 8'h00;
            awpriv_q <= 1'b0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
        end else begin
            if (aw_hs) begin
                aw_got_q <= 1'b1;
                awaddr_q <= 8'(awaddr);
                awpriv_q <= awprot[0];
            end else if (wr_fire) begin
                aw_got_q <= 1'b0;
            end
            if (w_hs) begin
                w_got_q <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (wr_fire) begin
                w_got_q <= 1'b0;
            end
            awready_q <= !aw_hs && !aw_got_q && !bvalid_q && !wr_fire;
            wready_q <= !w_hs && !w_got_q && !bvalid_q && !wr_fire;
        end
    end

    // Write response; unmapped offsets answer with an error
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= weg_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_mapped ? weg_pkg::RESP_OKAY : weg_pkg::RESP_SLVERR;
        end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
        end
    end

    // Read decode and data selection
    wire [7:0] ra = 8'(araddr);
    wire rs_ctrl = ra == weg_pkg::OFF_CTRL;
    wire rs_cfg = ra == weg_pkg::OFF_CFG;
    wire rs_stat = ra == weg_pkg::OFF_STAT;
    wire rs_ist = ra == weg_pkg::OFF_IRQ_STAT;
    wire rs_ien = ra == weg_pkg::OFF_IRQ_EN;
    wire rs_icl = ra == weg_pkg::OFF_IRQ_CLR;
    wire rd_mapped = rs_ctrl || rs_cfg || rs_stat || rs_ist || rs_ien || rs_icl;
    wire [31:0] stat_word = {cnt_q, 9'h0, seen_q, slow_q, dis_q,
        mode_q == weg_pkg::ST_PREWARN, mode_q == weg_pkg::ST_TIMEOUT, endinit_q, locked_q};
    wire [31:0] rd_data = rs_ctrl ? ctrl_rd :
        rs_cfg ? cfg_rd :
        rs_stat ? stat_word :
        rs_ist ? {27'h0, stat_q} :
        rs_ien ? {27'h0, en_q} : 32'h0;

    // Read channel; the clear register reads as zero
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_q <= weg_pkg::RESP_OKAY;
        end else if (ar_hs) begin
            arready_q <= 1'b0;
            rvalid_q <= 1'b1;
            rdata_q <= rd_data;
            rresp_q <= rd_mapped ? weg_pkg::RESP_OKAY : weg_pkg::RESP_SLVERR;
        end else if (rvalid_q && rready) begin
            rvalid_q <= 1'b0;
        end else if (!rvalid_q) begin
            arready_q <= 1'b1;
        end
    end

    assign awready = awready_q;
    assign wready = wready_q;
    assign bvalid = bvalid_q;
    assign bresp = bresp_q;
    assign arready = arready_q;
    assign rvalid = rvalid_q;
    assign rdata = rdata_q;
    assign rresp = rresp_q;
    assign endinit_line = endinit_q; // [R5]
    assign wd_nmi = nmi_q;
    assign wd_reset = reset_q;
    assign wd_wake = wake_q;
    assign irq = irq_q;
endmodule

// *** design/weg_pkg.sv ***
// Shared constants, register map and state codes of the watchdog guard
package weg_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CFG = 8'h04;
    localparam logic [7:0] OFF_STAT = 8'h08;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
    localparam logic [7:0] OFF_IRQ_EN = 8'h10;
    localparam logic [7:0] OFF_IRQ_CLR = 8'h14;
    // Control word fields
    localparam int CTL_ENDINIT = 0;
    localparam int CTL_GUARD = 1;
    localparam int CTL_PWU_LSB = 2;
    localparam int CTL_PWF_LSB = 8;
    localparam int CTL_REL_LSB = 16;
    // Fixed password field, value is arbitrary
    localparam logic [7:0] PW_FIXED = 8'h3c;
    localparam logic [5:0] PWU_RST = 6'h00;
    // Configuration word fields
    localparam int CFG_DIS = 0;
    localparam int CFG_SLOW = 1;
    // Status word fields
    localparam int SR_CNT_LSB = 16;
    // Reload and compare values
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [15:0] TIMEOUT_RELOAD = 16'hfffc;
    localparam logic [15:0] PREWARN_RELOAD = 16'hfffc;
    localparam logic [15:0] CNT_TOP = 16'hffff;
    localparam logic [15:0] WAKE_FROM = 16'h7fff;
    // Prescaler ratios
    localparam int DIV_FAST = 256;
    localparam int DIV_SLOW = 16384;
    // Reset request pulse length in cycles
    localparam logic [4:0] RST_PULSE_CYC = 5'd16;
    // Event bits
    localparam int IRQ_ACC = 0;
    localparam int IRQ_OVF = 1;
    localparam int IRQ_PREW = 2;
    localparam int IRQ_WAKE = 3;
    localparam int IRQ_EINIT = 4;
    localparam int IRQ_W = 5;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Watchdog modes
    typedef enum logic [4:0] {
        ST_NORMAL = 5'b00001,
        ST_TIMEOUT = 5'b00010,
        ST_PREWARN = 5'b00100,
        ST_RESET = 5'b01000,
        ST_HELD = 5'b10000
    } weg_mode_t;
endpackage

// *** design/weg_prescaler.sv ***
// Clock prescaler giving a one-cycle counting enable
`timescale 1ns/10ps
module weg_prescaler #(
    parameter int DIV_FAST = 256,
    parameter int DIV_SLOW = 16384
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic slow,
    output logic tick
);
    localparam int CW = $clog2(DIV_SLOW);
    localparam logic [CW-1:0] M_FAST = CW'(DIV_FAST - 1);
    localparam logic [CW-1:0] M_SLOW = CW'(DIV_SLOW - 1);

    logic [CW-1:0] cnt_q;
    wire [CW-1:0] mask = slow ? M_SLOW : M_FAST;

    // Free running; low bits all ones once per period of either ratio
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign tick = (cnt_q & mask) == mask;
endmodule

// *** design/weg_access_check.sv ***
// Password and guard bit check of a control word write
`timescale 1ns/10ps
module weg_access_check (
    input wire logic [31:0] data,
    input wire logic [5:0] pw_user,
    output logic pw_ok,
    output logic guard_ok
);
    wire fixed_ok = data[weg_pkg::CTL_PWF_LSB +: 8] == weg_pkg::PW_FIXED;
    wire user_ok = data[weg_pkg::CTL_PWU_LSB +: 6] == pw_user;

    // First write: full password, guard low, end-of-init kept set
    assign pw_ok = fixed_ok && user_ok && !data[weg_pkg::CTL_GUARD]
        && data[weg_pkg::CTL_ENDINIT];
    // Second write: guard high and fixed field intact
    assign guard_ok = fixed_ok && data[weg_pkg::CTL_GUARD];
endmodule

// *** tb/weg_guard_chk_assertions.sv ***
// Concurrent checks on the watchdog guard top-level ports
`timescale 1ns/10ps
module weg_guard_chk #(
    parameter int ADDR_W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic arvalid,
    input wire logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic rvalid,
    input wire logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp,
    input wire logic bvalid,
    input wire logic bready,
    input wire logic [1:0] bresp,
    input wire logic endinit_line,
    input wire logic wd_nmi,
    input wire logic wd_reset,
    input wire logic wd_wake
);
    int gap_q;
    int since_q;
    logic [4:0] hi_q;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Quiet time after a warning, reset pulse length, time since last warning
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 0;
            hi_q <= 5'h0;
            since_q <= 100000;
        end else begin
            gap_q <= wd_nmi ? 700 : ((gap_q != 0) ? gap_q - 1 : 0);
            hi_q <= !wd_reset ? 5'h0 : ((hi_q == 5'h1f) ? hi_q : hi_q + 5'h1);
            since_q <= wd_nmi ? 0 : ((since_q < 100000) ? since_q + 1 : since_q);
        end
    end
    sequence s_ar_take;
        arvalid && arready;
    endsequence
    sequence s_ar_bad;
        s_ar_take ##0 (araddr >= 8'h18);
    endsequence
    sequence s_r_err;
        rvalid && (rresp == weg_pkg::RESP_SLVERR) && (rdata == 32'h0);
    endsequence
    AST_BAD_READ: assert property (s_ar_bad |=> s_r_err)
        else $error("unmapped read not refused");
    AST_READ_LAT: assert property (s_ar_take |=> rvalid)
        else $error("read answer late");
    AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
        else $error("read data dropped early");
    AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write answer dropped early");
    AST_NMI_PULSE: assert property (wd_nmi |=> !wd_nmi)
        else $error("warning pulse too long");
    AST_WAKE_PULSE: assert property (wd_wake |=> !wd_wake)
        else $error("wake pulse too long");
    AST_RST_GAP: assert property (gap_q != 0 |-> !wd_reset)
        else $error("reset too soon after warning");
    AST_RST_LEN: assert property ($fell(wd_reset) |-> hi_q == weg_pkg::RST_PULSE_CYC)
        else $error("reset pulse length wrong");
    AST_RST_CAUSE: assert property ($rose(wd_reset) |-> since_q < 70000)
        else $error("reset without warning");
    AST_ENDINIT_FALL: assert property ($fell(endinit_line) |->
        bvalid || $past(bvalid) || $past(bvalid, 2))
        else $error("protection line dropped without write");
endmodule

bind weg_guard weg_guard_chk #(.ADDR_W(ADDR_W)) weg_guard_chk_i (
    .aclk(aclk), .aresetn(aresetn), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .endinit_line(endinit_line),
    .wd_nmi(wd_nmi), .wd_reset(wd_reset), .wd_wake(wd_wake));

// *** tb/weg_cpu_model.sv ***
// CPU side bus master model servicing the watchdog over AXI4-Lite
`timescale 1ns/10ps
module weg_cpu_model (
    input wire logic aclk,
    output logic awvalid,
    input wire logic awready,
    output logic [7:0] awaddr,
    output logic [2:0] awprot,
    output logic wvalid,
    input wire logic wready,
    output logic [31:0] wdata,
    output logic [3:0] wstrb,
    input wire logic bvalid,
    output logic bready,
    input wire logic [1:0] bresp,
    output logic arvalid,
    input wire logic arready,
    output logic [7:0] araddr,
    output logic [2:0] arprot,
    input wire logic rvalid,
    output logic rready,
    input wire logic [31:0] rdata,
    input wire logic [1:0] rresp
);
    int hung = 0;
    // Quiet bus at time zero
    initial begin
        {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
        {awaddr, awprot, wdata, wstrb, araddr, arprot} = '0;
    end
    // One register write; released lines show inverted data, not the old value
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [2:0] p,
            output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        awprot <= p;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awready && awvalid) begin
                awvalid <= 1'b0;
                awaddr <= ~a;
            end
            if (wready && wvalid) begin
                wvalid <= 1'b0;
                wdata <= ~d;
            end
        end while (!bvalid && n < 300);
        r = bresp;
        bready <= 1'b0;
        if (!bvalid) hung++;
    endtask
    // One register read
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arready && arvalid) begin
                arvalid <= 1'b0;
                araddr <= ~a;
            end
        end while (!rvalid && n < 300);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        if (!rvalid) hung++;
    endtask
endmodule

// *** tb/weg_guard_tb.sv ***
// Self-checking bench of the watchdog guard
`timescale 1ns/10ps
module weg_guard_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic low_power = 1'b0;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    logic rvalid, rready, endinit_line, wd_nmi, wd_reset, wd_wake, irq;
    logic [7:0] awaddr, araddr;
    logic [2:0] awprot, arprot;
    logic [31:0] wdata, rdata, d, e;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    int n_fail = 0;
    int comparisons = 0;
    int n_nmi = 0;
    int n_wake = 0;
    int n_rhi = 0;
    int n0;

    always #20 aclk = ~aclk;
    // Tallies of pulses and reset cycles, so no short pulse is missed
    always @(posedge aclk) begin
        if (wd_nmi === 1'b1) n_nmi++;
        if (wd_wake === 1'b1) n_wake++;
        if (wd_reset === 1'b1) n_rhi++;
    end

    weg_guard weg_guard_i (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid),
        .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(arprot), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .low_power(low_power), .endinit_line(endinit_line), .wd_nmi(wd_nmi),
        .wd_reset(wd_reset), .wd_wake(wd_wake), .irq(irq));
    weg_cpu_model weg_cpu_model_i (.aclk(aclk), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp));

    task chk(input logic [31:0] s, input logic [31:0] x);
        comparisons++;
        if (s !== x) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, x);
        end
    endtask
    task close_out;
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask
    task w(input logic [7:0] a, input logic [31:0] v, input logic [2:0] p);
        weg_cpu_model_i.wr(a, v, p, r);
    endtask
    task rc(input logic [7:0] a, input logic [31:0] x);
        weg_cpu_model_i.rd(a, d, r);
        chk(d, x);
    endtask
    // Bounded wait for a tally to move; running out ends the run
    task automatic wt(ref int c, input int c0, input int lim);
        int k;
        k = 0;
        while (c == c0 && k < lim) begin
            @(posedge aclk);
            k++;
        end
        if (c == c0) begin
            n_fail++;
            $display("CHECK FAILED t=%0t wait ran out", $time);
            close_out;
        end
    endtask

    initial begin
        cyc(5);
        aresetn <= 1'b1;
        cyc(2);
        chk(32'(endinit_line), 32'h1);
        rc(weg_pkg::OFF_STAT, 32'h3);
        rc(8'h18, 32'h0);
        chk(32'(r), 32'(weg_pkg::RESP_SLVERR));
        w(weg_pkg::OFF_IRQ_EN, 32'h1f, 3'h0);
        rc(weg_pkg::OFF_IRQ_EN, 32'h1f);
        // Config refused while end-of-init is still set
        w(weg_pkg::OFF_CFG, 32'h2, 3'h1);
        rc(weg_pkg::OFF_STAT, 32'h3);
        w(weg_pkg::OFF_CTRL, 32'h00003c01, 3'h0);
        w(weg_pkg::OFF_CTRL, 32'h7ff03c02, 3'h0);
        cyc(2);
        chk(32'(endinit_line), 32'h0);
        chk(32'(irq), 32'h1);
        rc(weg_pkg::OFF_IRQ_STAT, 32'h10);
        weg_cpu_model_i.rd(weg_pkg::OFF_STAT, d, r);
        chk(d & 32'hffff, 32'h1);
        chk(d & 32'hfff00000, 32'h7ff00000);
        // Count crosses the half-way mark while the system sleeps
        low_power <= 1'b1;
        wt(n_wake, n_wake, 5000);
        low_power <= 1'b0;
        rc(weg_pkg::OFF_IRQ_STAT, 32'h18);
        w(weg_pkg::OFF_IRQ_EN, 32'h0, 3'h0);
        cyc(2);
        chk(32'(irq), 32'h0);
        w(weg_pkg::OFF_IRQ_CLR, 32'h1f, 3'h0);
        rc(weg_pkg::OFF_IRQ_STAT, 32'h0);
        w(weg_pkg::OFF_IRQ_EN, 32'h1f, 3'h0);
        // Without supervisor mark the config stays; with it the time-out is off
        w(weg_pkg::OFF_CFG, 32'h2, 3'h1);
        w(weg_pkg::OFF_CFG, 32'h1, 3'h0);
        rc(weg_pkg::OFF_CFG, 32'h2);
        w(weg_pkg::OFF_CFG, 32'h1, 3'h1);
        weg_cpu_model_i.rd(weg_pkg::OFF_STAT, d, r);
        chk(d & 32'h30, 32'h10);
        e = d & 32'hffff0000;
        cyc(600);
        weg_cpu_model_i.rd(weg_pkg::OFF_STAT, d, r);
        chk(d & 32'hffff0000, e);
        // Wrong fixed password is caught even with the time-out off
        n0 = n_nmi;
        w(weg_pkg::OFF_CTRL, 32'h00005501, 3'h0);
        wt(n_nmi, n0, 50);
        weg_cpu_model_i.rd(weg_pkg::OFF_IRQ_STAT, d, r);
        chk(d & 32'h7, 32'h5);
        wt(n_rhi, n_rhi, 2000);
        cyc(40);
        chk(32'(n_rhi), 32'(weg_pkg::RST_PULSE_CYC));
        chk(32'(endinit_line), 32'h1);
        // Bad guard bits on the second write; second reset holds the chip
        w(weg_pkg::OFF_CTRL, 32'h00003c01, 3'h0);
        n0 = n_nmi;
        w(weg_pkg::OFF_CTRL, 32'h00003c00, 3'h0);
        wt(n_nmi, n0, 50);
        wt(n_rhi, n_rhi, 2000);
        cyc(300);
        chk(32'(wd_reset), 32'h1);
        aresetn <= 1'b0;
        cyc(2);
        aresetn <= 1'b1;
        cyc(2);
        chk(32'(wd_reset), 32'h0);
        // No service after a short reload: overflow error
        w(weg_pkg::OFF_CTRL, 32'h00003c01, 3'h0);
        w(weg_pkg::OFF_CTRL, 32'hfff03c03, 3'h0);
        wt(n_nmi, n_nmi, 5000);
        rc(weg_pkg::OFF_IRQ_STAT, 32'h6);
        wt(n_rhi, n_rhi, 2000);
        cyc(40);
        // First write never followed by the second one
        w(weg_pkg::OFF_CTRL, 32'h00003c01, 3'h0);
        n0 = n_nmi;
        cyc(1400);
        chk(32'(n_nmi), 32'(n0 + 1));
        chk(32'(weg_cpu_model_i.hung), 32'h0);
        close_out;
    end
endmodule
